// ===== common/ecs_pkg.sv
package ecs_pkg;
  // Register map, byte addresses
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] CTRL1_OFF = 6'h00;
  localparam logic [5:0] RXST_OFF = 6'h04;
  localparam logic [5:0] IEN_OFF = 6'h08;
  localparam logic [5:0] STAT_OFF = 6'h0C;
  localparam logic [5:0] FLAG_OFF = 6'h10;
  localparam logic [5:0] MODE_OFF = 6'h14;
  // Control register fields
  localparam int unsigned CTRL_ON = 15;
  localparam int unsigned CTRL_AFC = 7;
  localparam int unsigned CTRL_DEC = 0;
  // Interrupt enable and event flag positions
  localparam logic [15:0] IEN_MASK = 16'h63EF;
  localparam int unsigned EV_TXBUSE = 14;
  localparam int unsigned EV_RXBUSE = 13;
  localparam int unsigned EV_EWMARK = 9;
  localparam int unsigned EV_FWMARK = 8;
  localparam int unsigned EV_RXDONE = 7;
  localparam int unsigned EV_PEND = 6;
  localparam int unsigned EV_RXACT = 5;
  localparam int unsigned EV_TXDONE = 3;
  localparam int unsigned EV_TXABORT = 2;
  localparam int unsigned EV_RXBUFNA = 1;
  localparam int unsigned EV_RXOVF = 0;
  // Status register fields
  localparam int unsigned STAT_CNT_LSB = 16;
  localparam int unsigned STAT_BUSY = 7;
  localparam int unsigned STAT_TX_BUSY_FLAG = 6;
  localparam int unsigned STAT_RX_BUSY_FLAG = 5;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // Input pin order within one pin set
  localparam int unsigned PIN_N = 10;
  localparam int unsigned PIN_RXCLK = 0;
  localparam int unsigned PIN_TXCLK = 1;
  localparam int unsigned PIN_RXDV = 2;
  localparam int unsigned PIN_RXERR = 3;
  localparam int unsigned PIN_CRS = 4;
  localparam int unsigned PIN_COL = 5;
  localparam int unsigned PIN_RXD0 = 6;
  // Claimed pins: 10 inputs, then txd0..3, txen, txerr
  localparam logic [15:0] OWN_MII = 16'hFFFF;
  localparam logic [15:0] OWN_RMII = 16'h4CCD;
  localparam logic [1:0] FUSE_WAIT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ===== hw/ecs_ctrl_status.sv
`timescale 1ns/100ps
// Operation
// - MII fuse 1 and pin fuse 1: full MII set on default pins.
// - MII fuse 0 and pin fuse 1: reduced RMII set on default pins.
// - Pin fuse 0: chosen signal set goes to the alternate pins.
// - Pins the chosen interface does not use are released.
// - Enable bits 14 and 13 gate transmit and receive bus error interrupts.
// - Enable bit 9 gates empty watermark, bit 8 full watermark.
// - Enable bits 7, 6, 5 gate receive done, pending, receive activity.
// - Enable bits 3 and 2 gate transmit done and transmit abort.
// - Enable bit 1 gates no receive buffer, bit 0 receive overrun.
// - Unused enable bits read zero; enable bits reset to zero.
// - Counter grows by descriptors used after each good reception.
// - Counter saturates at its maximum, never wraps to zero.
// - Counter holds at zero on decrement, never wraps to maximum.
// - Decrement and increment in one cycle leave counter unchanged.
// - With flow control on, receive halts while counter is at maximum.
// - With flow control off, receive keeps running at maximum count.
// - Pending flag follows non-zero counter; interrupts only when enabled.
// - Start address write clears counter; switching off keeps it.
// - Busy reads one while on or finishing a transaction.
// - Transmit and receive busy flags clear while module is off.
module ecs_ctrl_status #(
  parameter int unsigned DESC_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ecs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ecs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic full_mii_select_fuse,
  input wire logic default_pinset_fuse,
  input wire logic [9:0] def_pin_in,
  input wire logic [9:0] alt_pin_in,
  output logic [5:0] def_pin_out,
  output logic [5:0] def_pin_oe,
  output logic [5:0] alt_pin_out,
  output logic [5:0] alt_pin_oe,
  output logic [15:0] def_pin_own,
  output logic [15:0] alt_pin_own,
  input wire logic [5:0] mac_tx,
  output logic [7:0] mac_rx,
  output logic mac_rmii,
  input wire logic [15:0] evt_in,
  input wire logic rx_pkt_done,
  input wire logic [DESC_W-1:0] rx_pkt_desc,
  input wire logic tx_active,
  input wire logic rx_active,
  output logic rx_halt,
  output logic [31:0] rx_start_addr,
  output logic module_on,
  output logic irq
);

  // Refused at elaboration: the counter sum is only nine bits wide
  if (DESC_W < 1 || DESC_W > 8) begin : g_bad_desc
    $error("DESC_W must be 1 to 8");
  end

  typedef struct packed {
    logic [21:0] s1;
    logic [21:0] s2;
    logic [1:0] fcnt;
    logic fmii;
    logic fdef;
    logic rclk_prev;
    logic dv_prev;
    logic [7:0] mrx;
    logic [5:0] tx;
    logic [ecs_pkg::ADDR_W-1:0] awaddr;
    logic awgot;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wgot;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic on;
    logic afc;
    logic [15:0] ien;
    logic [15:0] flags;
    logic [7:0] cnt;
    logic [31:0] rxst;
  } ecs_state_s;

  ecs_state_s q;
  ecs_state_s n;
  logic fuse_ok;
  logic [9:0] sel;
  logic [15:0] own;
  logic do_wr;
  logic inc;
  logic dec;
  logic clr;
  logic pend;
  logic busy;
  logic tx_busy;
  logic rx_busy;
  logic [15:0] flag_view;
  logic [8:0] sum;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic [31:0] rd;
  logic act;
  logic [5:0] rd_addr;
  logic [5:0] wr_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin set selection from captured fuses
  assign fuse_ok = (q.fcnt == ecs_pkg::FUSE_WAIT);
  assign own = q.fmii ? ecs_pkg::OWN_MII : ecs_pkg::OWN_RMII;
  assign sel = q.fdef ? q.s2[9:0] : q.s2[19:10];
  // Unused pins released so other peripherals may take them
  assign def_pin_own = (fuse_ok && q.fdef) ? own : 16'h0000;
  assign alt_pin_own = (fuse_ok && !q.fdef) ? own : 16'h0000;
  assign def_pin_oe = def_pin_own[15:10];
  assign alt_pin_oe = alt_pin_own[15:10];
  assign def_pin_out = q.tx;
  assign alt_pin_out = q.tx;
  assign mac_rx = q.mrx;
  assign mac_rmii = fuse_ok && !q.fmii;

  ////////////////////////////////////////////////////////////////////////////
  // Status view and interrupt
  assign pend = (q.cnt != ecs_pkg::CNT_ZERO);
  assign busy = q.on || tx_active || rx_active;
  assign tx_busy = q.on && tx_active;
  assign rx_busy = q.on && rx_active;
  assign flag_view = q.flags | (16'(pend) << ecs_pkg::EV_PEND);
  // One enable bit per flag at the same position
  assign irq = |(flag_view & q.ien);
  assign rx_halt = q.afc && (q.cnt == ecs_pkg::CNT_MAX);
  assign rx_start_addr = q.rxst;
  assign module_on = q.on;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes: one write and one read held at a time
  assign s_axi_awready = !q.awgot && !q.bvalid;
  assign s_axi_wready = !q.wgot && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign do_wr = q.awgot && q.wgot && !q.bvalid;
  assign rd_addr = {s_axi_araddr[5:2], 2'h0};
  assign wr_addr = {q.awaddr[5:2], 2'h0};

  // Byte lanes expanded to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{q.wstrb[i]}};
    end
  end

  // Read data mux; reserved bits read as zero
  always_comb begin
    rd = 32'h0000_0000;
    unique case (rd_addr)
      ecs_pkg::CTRL1_OFF: begin
        rd[ecs_pkg::CTRL_ON] = q.on;
        rd[ecs_pkg::CTRL_AFC] = q.afc;
      end
      ecs_pkg::RXST_OFF: rd = q.rxst;
      ecs_pkg::IEN_OFF: rd[15:0] = q.ien;
      ecs_pkg::STAT_OFF: begin
        rd[ecs_pkg::STAT_CNT_LSB +: 8] = q.cnt;
        rd[ecs_pkg::STAT_BUSY] = busy;
        rd[ecs_pkg::STAT_TX_BUSY_FLAG] = tx_busy;
        rd[ecs_pkg::STAT_RX_BUSY_FLAG] = rx_busy;
      end
      ecs_pkg::FLAG_OFF: rd[15:0] = flag_view;
      ecs_pkg::MODE_OFF: rd[1:0] = {q.fdef, q.fmii};
      default: rd = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q;
    merged = (q.wdata & wmask);
    inc = 1'b0;
    dec = 1'b0;
    clr = 1'b0;
    act = 1'b0;
    sum = 9'h000;
    // Pins and fuses come from outside: two stages before use
    n.s1 = {default_pinset_fuse, full_mii_select_fuse, alt_pin_in, def_pin_in};
    n.s2 = q.s1;
    // Straps caught once the synchroniser has filled after reset
    if (!fuse_ok) begin
      n.fcnt = q.fcnt + 2'h1;
      n.fmii = q.s2[20];
      n.fdef = q.s2[21];
    end
    // Receive side, widened to the 4-bit view in RMII
    if (q.fmii) begin
      n.mrx = {sel[ecs_pkg::PIN_RXD0 +: 4], sel[ecs_pkg::PIN_RXDV],
        sel[ecs_pkg::PIN_RXERR], sel[ecs_pkg::PIN_CRS], sel[ecs_pkg::PIN_COL]};
    end else begin
      n.mrx = {2'h0, sel[ecs_pkg::PIN_RXD0 +: 2], sel[ecs_pkg::PIN_RXDV],
        sel[ecs_pkg::PIN_RXERR], sel[ecs_pkg::PIN_RXDV], 1'b0};
    end
    if (!fuse_ok) begin
      n.mrx = 8'h00;
    end
    // Transmit side; RMII drives only two data bits and enable
    n.tx = fuse_ok ? (mac_tx & own[15:10]) : 6'h00;
    // Receive activity: data valid rising at a receive clock edge
    n.rclk_prev = sel[ecs_pkg::PIN_RXCLK];
    if (sel[ecs_pkg::PIN_RXCLK] && !q.rclk_prev) begin
      n.dv_prev = sel[ecs_pkg::PIN_RXDV];
      act = sel[ecs_pkg::PIN_RXDV] && !q.dv_prev && fuse_ok;
    end
    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.awgot = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.wgot = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Register write, answered one cycle after both halves are held
    if (do_wr) begin
      n.awgot = 1'b0;
      n.wgot = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = ecs_pkg::RESP_OKAY;
      unique case (wr_addr)
        ecs_pkg::CTRL1_OFF: begin
          merged = (q.wdata & wmask) | ({16'h0, q.on, 7'h00, q.afc, 7'h00} & ~wmask);
          n.on = merged[ecs_pkg::CTRL_ON];
          n.afc = merged[ecs_pkg::CTRL_AFC];
          dec = merged[ecs_pkg::CTRL_DEC] && q.wstrb[0];
        end
        ecs_pkg::RXST_OFF: begin
          n.rxst = (q.wdata & wmask) | (q.rxst & ~wmask);
          clr = 1'b1;
        end
        ecs_pkg::IEN_OFF: begin
          merged = (q.wdata & wmask) | ({16'h0, q.ien} & ~wmask);
          n.ien = merged[15:0] & ecs_pkg::IEN_MASK;
        end
        ecs_pkg::FLAG_OFF: begin
          n.flags = q.flags & ~merged[15:0];
        end
        ecs_pkg::STAT_OFF, ecs_pkg::MODE_OFF: begin
          n.bresp = ecs_pkg::RESP_OKAY;
        end
        default: n.bresp = ecs_pkg::RESP_DECERR;
      endcase
    end
    // Event flags: a new event beats a clear in the same cycle
    n.flags = (n.flags | evt_in | (16'(act) << ecs_pkg::EV_RXACT))
      & ecs_pkg::IEN_MASK & ~(16'h1 << ecs_pkg::EV_PEND);
    // Buffer counter; switching off leaves it alone
    inc = rx_pkt_done;
    sum = {1'b0, q.cnt} + 9'(rx_pkt_desc);
    if (clr) begin
      n.cnt = ecs_pkg::CNT_ZERO;
    end else if (inc && dec) begin
      n.cnt = q.cnt;
    end else if (inc) begin
      n.cnt = sum[8] ? ecs_pkg::CNT_MAX : sum[7:0];
    end else if (dec && q.cnt != ecs_pkg::CNT_ZERO) begin
      n.cnt = q.cnt - 8'h01;
    end
    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = ecs_pkg::RESP_OKAY;
      if (rd_addr > ecs_pkg::MODE_OFF) begin
        n.rresp = ecs_pkg::RESP_DECERR;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Buffer counter
  a_cnt_sat_top: assert property (q.cnt == 8'hFF && inc && !dec && !clr |=> q.cnt == 8'hFF)
    else $error("counter wrapped above maximum");
  a_cnt_hold_zero: assert property (q.cnt == 8'h00 && dec && !inc && !clr |=> q.cnt == 8'h00)
    else $error("counter wrapped below zero");
  a_cnt_both_hold: assert property (inc && dec && !clr |=> $stable(q.cnt))
    else $error("counter moved on simultaneous inc and dec");
  a_cnt_inc_by: assert property (inc && !dec && !clr
    && ({1'b0, q.cnt} + 9'(rx_pkt_desc)) < 9'h100
    |=> q.cnt == $past(q.cnt) + $past(rx_pkt_desc))
    else $error("counter did not add descriptor count");
  a_rxst_clear: assert property (do_wr && wr_addr == 6'h04 |=> q.cnt == 8'h00)
    else $error("start address write did not clear counter");
  a_off_keeps_cnt: assert property (q.on && !n.on && !inc && !dec && !clr |=> $stable(q.cnt))
    else $error("counter changed on switch off");
  // Flow control and pending packets
  a_halt_full: assert property (q.afc && q.cnt == 8'hFF |-> rx_halt)
    else $error("receive not halted at full count");
  a_no_halt_nofc: assert property (!q.afc |-> !rx_halt)
    else $error("receive halted with flow control off");
  a_halt_release: assert property (rx_halt && dec && !inc && !clr |=> !rx_halt)
    else $error("receive still halted after decrement");
  a_pend_irq: assert property (q.cnt != 8'h00 && q.ien[6] |-> irq)
    else $error("pending packet did not interrupt");
  a_pend_read: assert property (s_axi_arvalid && s_axi_arready && rd_addr == 6'h10
    && q.cnt != 8'h00 |=> s_axi_rdata[6])
    else $error("pending flag not set with packets held");
  a_irq_quiet: assert property (q.flags == 16'h0 && q.cnt == 8'h00 |-> !irq)
    else $error("interrupt with no flag set");
  // Busy flags seen through the read path, so a broken read mux trips them too; then enable mask and pin ownership
  a_busy_on: assert property (q.on && s_axi_arvalid && s_axi_arready
    && rd_addr == 6'h0C |=> s_axi_rdata[7])
    else $error("busy low while on");
  a_sub_busy_off: assert property (!q.on && s_axi_arvalid && s_axi_arready
    && rd_addr == 6'h0C |=> s_axi_rdata[6:5] == 2'h0)
    else $error("sub busy set while off");
  a_ien_reserved: assert property (q.ien == (q.ien & 16'h63EF))
    else $error("reserved enable bit set");
  a_rmii_pins: assert property (fuse_ok && !q.fmii && q.fdef
    |-> def_pin_own == 16'h4CCD && alt_pin_own == 16'h0000)
    else $error("RMII default pins wrong");
  a_alt_pins: assert property (fuse_ok && !q.fdef |-> def_pin_oe == 6'h00)
    else $error("default pins driven in alternate mode");
  // Event flags
  a_event_sets: assert property (evt_in != 16'h0
    |=> (q.flags & $past(evt_in) & 16'h63AF) == ($past(evt_in) & 16'h63AF))
    else $error("event did not set its flag");

  c_cnt_saturate: cover property (q.cnt == 8'hFF && inc);
  c_flow_halt: cover property (rx_halt && rx_pkt_done);
  c_inc_dec: cover property (inc && dec);
  c_rx_activity: cover property (act);
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);

endmodule

// ===== verif/ecs_phy_model.sv
`timescale 1ns/100ps
module ecs_phy_model (
  output logic [9:0] pins
);
  logic clk_l = 1'h0;
  logic dv = 1'h0;
  logic [3:0] nib = 4'h0;
  logic [3:0] idle_q = 4'h5;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle data keeps toggling so a stale nibble never passes for a valid one
  always #24 idle_q = ~idle_q;
  // Order: rxd3..0, col, crs, err, dv, txclk, rxclk; crs follows dv
  assign pins = {dv ? nib : idle_q, 1'h0, dv, 1'h0, dv, clk_l, clk_l};
  ////////////////////////////////////////////////////////////////////////////////
  // Clock runs only while send_frame runs; gap adds idle clocks before the frame, as a slow PHY would
  task automatic send_frame(input logic [3:0] d, input int n, input int gap);
    repeat (gap) begin
      #24 clk_l = 1'h1;
      #24 clk_l = 1'h0;
    end
    dv = 1'h1;
    nib = d;
    repeat (n) begin
      #24 clk_l = 1'h1;
      #24 clk_l = 1'h0;
    end
    dv = 1'h0;
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam logic [31:0] ON_B = 32'h1 << ecs_pkg::CTRL_ON;
  localparam logic [31:0] AFC_B = 32'h1 << ecs_pkg::CTRL_AFC;
  localparam logic [31:0] DEC_B = 32'h1 << ecs_pkg::CTRL_DEC;
  localparam logic [31:0] CNT_M = 32'h00FF0000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic full_mii_select_fuse = 1'h1, default_pinset_fuse = 1'h1;
  logic [5:0] mac_tx = 6'h3F;
  logic [15:0] evt_in = 16'h0;
  logic rx_pkt_done = 1'h0, tx_active = 1'h0, rx_active = 1'h0;
  logic [7:0] rx_pkt_desc = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bsp, rsp;
  logic [31:0] s_axi_rdata, rx_start_addr, rdv;
  logic [9:0] phy_pins, def_pin_in, alt_pin_in;
  logic [5:0] def_pin_out, def_pin_oe, alt_pin_out, alt_pin_oe;
  logic [15:0] def_pin_own, alt_pin_own;
  logic [7:0] mac_rx;
  logic mac_rmii, rx_halt, module_on, irq;
  int bad_count = 0;
  int n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Unselected pin set sees inverted traffic, never a copy of the real one
  assign def_pin_in = default_pinset_fuse ? phy_pins : ~phy_pins;
  assign alt_pin_in = default_pinset_fuse ? ~phy_pins : phy_pins;
  ecs_ctrl_status #(.DESC_W(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .full_mii_select_fuse,
    .default_pinset_fuse, .def_pin_in, .alt_pin_in, .def_pin_out, .def_pin_oe, .alt_pin_out,
    .alt_pin_oe, .def_pin_own, .alt_pin_own, .mac_tx, .mac_rx, .mac_rmii, .evt_in,
    .rx_pkt_done, .rx_pkt_desc, .tx_active, .rx_active, .rx_halt, .rx_start_addr,
    .module_on, .irq);
  ecs_phy_model phy_u (.pins(phy_pins));
  // Clock, 5 ns period
  initial forever #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Verdict; also reached by the watchdog
  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 200);
    if (n >= 200) bad_count++;
    bsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  // Read one word into rdv and rsp
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 200);
    if (n >= 200) bad_count++;
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a);
    chk(rdv & m, e);
  endtask
  // Reset long enough for the fuse synchronisers to settle
  task automatic rst();
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
  endtask
  task automatic pkt(input logic [7:0] d);
    rx_pkt_desc <= d;
    rx_pkt_done <= 1'h1;
    @(posedge aclk);
    rx_pkt_done <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // All four fuse combinations; ends on MII, default pins
  task automatic t_pins();
    logic [15:0] own;
    for (int i = 0; i < 4; i++) begin
      full_mii_select_fuse <= i[0];
      default_pinset_fuse <= i[1];
      rst();
      own = i[0] ? ecs_pkg::OWN_MII : ecs_pkg::OWN_RMII;
      chk(def_pin_own, i[1] ? own : 16'h0);
      chk(alt_pin_own, i[1] ? 16'h0 : own);
      chk(i[1] ? def_pin_oe : alt_pin_oe, own[15:10]);
      chk(i[1] ? def_pin_out : alt_pin_out, own[15:10]);
      chk(mac_rmii, !i[0]);
      rdc(ecs_pkg::MODE_OFF, {30'h0, i[1], i[0]}, 32'h3);
    end
  endtask
  // Enable register reset, mask and unmapped places
  task automatic t_ien();
    rdc(ecs_pkg::IEN_OFF, 32'h0, 32'hFFFFFFFF);
    wr(ecs_pkg::IEN_OFF, 32'hFFFFFFFF);
    rdc(ecs_pkg::IEN_OFF, 32'h63EF, 32'hFFFFFFFF);
    rd(6'h18);
    chk(rsp, ecs_pkg::RESP_DECERR);
    wr(6'h1C, 32'h1);
    chk(bsp, ecs_pkg::RESP_DECERR);
    wr(ecs_pkg::IEN_OFF, 32'h0);
  endtask
  // Every event source: raise, mask, clear
  task automatic t_irq();
    int pos[10] = '{14, 13, 9, 8, 7, 5, 3, 2, 1, 0};
    logic [31:0] m;
    foreach (pos[k]) begin
      m = 32'h1 << pos[k];
      wr(ecs_pkg::IEN_OFF, m);
      evt_in <= m[15:0];
      @(posedge aclk);
      evt_in <= 16'h0;
      repeat (3) @(posedge aclk);
      chk(irq, 1'h1);
      wr(ecs_pkg::IEN_OFF, 32'h0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h0);
      wr(ecs_pkg::FLAG_OFF, m);
      rdc(ecs_pkg::FLAG_OFF, 32'h0, m);
    end
  endtask
  // Buffer counter: grow, shrink, collide, saturate, halt, clear
  task automatic t_count();
    wr(ecs_pkg::CTRL1_OFF, ON_B | AFC_B);
    pkt(8'h03);
    rdc(ecs_pkg::STAT_OFF, 32'h00030000, CNT_M);
    rdc(ecs_pkg::FLAG_OFF, 32'h40, 32'h40);
    wr(ecs_pkg::IEN_OFF, 32'h40);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1);
    wr(ecs_pkg::IEN_OFF, 32'h0);
    wr(ecs_pkg::CTRL1_OFF, ON_B | AFC_B | DEC_B);
    rdc(ecs_pkg::STAT_OFF, 32'h00020000, CNT_M);
    // Twelve single increments, one of them meeting the decrement
    fork
      begin
        rx_pkt_desc <= 8'h01;
        rx_pkt_done <= 1'h1;
        repeat (12) @(posedge aclk);
        rx_pkt_done <= 1'h0;
      end
      begin
        @(posedge aclk);
        wr(ecs_pkg::CTRL1_OFF, ON_B | AFC_B | DEC_B);
      end
    join
    repeat (2) @(posedge aclk);
    rdc(ecs_pkg::STAT_OFF, 32'h000D0000, CNT_M);
    pkt(8'hFF);
    pkt(8'h01);
    rdc(ecs_pkg::STAT_OFF, 32'h00FF0000, CNT_M);
    chk(rx_halt, 1'h1);
    wr(ecs_pkg::CTRL1_OFF, ON_B | AFC_B | DEC_B);
    repeat (2) @(posedge aclk);
    chk(rx_halt, 1'h0);
    pkt(8'h01);
    wr(ecs_pkg::CTRL1_OFF, ON_B);
    chk(rx_halt, 1'h0);
    pkt(8'h05);
    rdc(ecs_pkg::STAT_OFF, 32'h00FF0000, CNT_M);
    wr(ecs_pkg::CTRL1_OFF, DEC_B);
    rdc(ecs_pkg::STAT_OFF, 32'h00FE0000, CNT_M);
    wr(ecs_pkg::RXST_OFF, 32'h00001000);
    chk(rx_start_addr, 32'h00001000);
    rdc(ecs_pkg::STAT_OFF, 32'h0, CNT_M);
    wr(ecs_pkg::CTRL1_OFF, DEC_B);
    rdc(ecs_pkg::STAT_OFF, 32'h0, CNT_M);
  endtask
  // Busy flags with the module switched on and off under traffic
  task automatic t_busy();
    wr(ecs_pkg::CTRL1_OFF, ON_B);
    chk(module_on, 1'h1);
    rdc(ecs_pkg::STAT_OFF, 32'h80, 32'hE0);
    tx_active <= 1'h1;
    rx_active <= 1'h1;
    repeat (2) @(posedge aclk);
    rdc(ecs_pkg::STAT_OFF, 32'hE0, 32'hE0);
    wr(ecs_pkg::CTRL1_OFF, 32'h0);
    chk(module_on, 1'h0);
    rdc(ecs_pkg::STAT_OFF, 32'h80, 32'hE0);
    tx_active <= 1'h0;
    rx_active <= 1'h0;
    repeat (2) @(posedge aclk);
    rdc(ecs_pkg::STAT_OFF, 32'h0, 32'hE0);
  endtask
  // One MII frame from the PHY on the default pins
  task automatic t_link();
    fork
      phy_u.send_frame(4'hA, 8, 2);
      begin
        #248;
        chk(mac_rx, 8'hAA);
      end
    join
    @(posedge aclk);
    rdc(ecs_pkg::FLAG_OFF, 32'h20, 32'h20);
    // Same frame in RMII on the alternate pins: only two data bits reach the MAC
    full_mii_select_fuse <= 1'h0;
    default_pinset_fuse <= 1'h0;
    rst();
    fork
      phy_u.send_frame(4'hA, 8, 2);
      begin
        #248;
        chk(mac_rx, 8'h2A);
      end
    join
    @(posedge aclk);
    rdc(ecs_pkg::FLAG_OFF, 32'h20, 32'h20);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    t_pins();
    t_ien();
    t_irq();
    t_count();
    t_busy();
    t_link();
    test_done();
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #300000;
    bad_count++;
    test_done();
  end
endmodule
